// [common/ovp_supervisor_pkg.sv]
/*
 * Constants for the converter supply and overvoltage supervisor: threshold
 * figures (for reference), overvoltage cycle counts and minimum delay.
 * Assumes a 50 MHz system clock.
 */
package ovp_supervisor_pkg;
    // system clock
    localparam int CLOCK_HZ         = 50_000_000;
    // supply thresholds in millivolts, resolved by external comparators
    localparam int START_MV         = 19100;
    localparam int HV_HYST_MV       = 700;
    localparam int STOP_MV          = 13200;
    localparam int RESET_MV         = 3500;
    localparam int LOW_MV           = 14000;
    localparam int LOW_HYST_MV      = 900;
    localparam int REG_ON_MV        = 11000;
    localparam int REG_UV_MV        = 9000;
    localparam int HS_UV_MV         = 7000;
    localparam int BOOST_UV_MV      = 1600;
    localparam int BOOST_START_MV   = 2300;
    localparam int OVP_MV           = 3500;
    // overvoltage delay in switching cycles
    localparam int OVP_CYCLES       = 11;
    localparam int OVP_CYCLES_MIN   = 10;
    localparam int OVP_CYCLES_MAX   = 12;
    // minimum overvoltage delay in microseconds
    localparam int OVP_MIN_US       = 75;
    localparam int OVP_MAX_US       = 90;
    localparam int OVP_MIN_CLKS     =
        (OVP_MIN_US * (CLOCK_HZ / 1_000_000));
    // supervisor states
    typedef enum logic [2:0] {
        ST_OFF, ST_CHARGE, ST_WAIT_REG, ST_WAIT_BOOST, ST_RUN, ST_PROTECT
    } sup_state_t;
endpackage

// [hw/ovp_supervisor.sv]
/*
 * Supply and overvoltage supervisor for a half-bridge resonant stage.
 * Reads comparator levels (asynchronous, synchronised here), the switching
 * cycle strobe and the low-side conduction level from the gate logic, and
 * drives switching enables, the high-voltage start-up source and resets.
 * Assumes comparators carry their own hysteresis only where stated below.
 */
`timescale 1ns/10ps

// Function
// - operation enabled only after main supply reaches the start level
// - high-voltage source toggles between start level and 0.7 V below it
// - converter stops once main supply drops under the stop level
// - main supply at reset level forces a full system reset
// - burst idle with main supply at low level switches source on
// - burst idle backup regulates supply within 0.9 V above low level
// - no half-bridge switching until regulated supply reaches regulation
// - regulated supply undervoltage stops all operation
// - bootstrap undervoltage stops the high-side driver
// - boost undervoltage halts switching while low side conducts
// - boost above start level starts or restarts switching
// - overvoltage after delay stops switching, latches or restarts safely
// - count overvoltage cycles, trigger at nominal count eleven
// - effective delay may be ten to twelve cycles
// - minimum delay in time of 75 to 90 microseconds
// - sense pin also selects burst repetition frequency setting
// - steady external overvoltage level trips with same delay
// - latched protection held until main supply or mains falls
module ovp_supervisor #(
    parameter int OVP_COUNT = ovp_supervisor_pkg::OVP_CYCLES,
    parameter int MIN_CLKS  = ovp_supervisor_pkg::OVP_MIN_CLKS
) (
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic SYS_RST,
    // main supply comparators, high when above the level
    input  wire logic MAIN_ABOVE_START,
    input  wire logic MAIN_ABOVE_HV_LOW,
    input  wire logic MAIN_ABOVE_STOP,
    input  wire logic MAIN_ABOVE_LOW,
    input  wire logic MAIN_ABOVE_LOW_HYST,
    input  wire logic MAIN_ABOVE_RESET,
    // regulated and bootstrap supply comparators
    input  wire logic REG_ABOVE_ON,
    input  wire logic REG_ABOVE_UV,
    input  wire logic HS_ABOVE_UV,
    // boost sense comparators
    input  wire logic BOOST_ABOVE_UV,
    input  wire logic BOOST_ABOVE_START,
    // output sense comparator and mains sense
    input  wire logic OUT_ABOVE_OVP,
    input  wire logic MAINS_OK,
    // switching timing and mode inputs
    input  wire logic CYCLE_STROBE,
    input  wire logic LOW_SIDE_ON,
    input  wire logic BURST_IDLE,
    input  wire logic SAFE_RESTART_MODE,
    // outputs
    output logic      SYSTEM_RESET,
    output logic      CONTROLLER_ENABLE,
    output logic      HV_SOURCE_ON,
    output logic      SWITCH_ENABLE,
    output logic      HIGH_SIDE_ENABLE,
    output logic      OVP_LATCHED,
    output logic      SAMPLE_SETTING
);
    localparam int NIN = 17;
    localparam int CW  = $clog2(OVP_COUNT + 1);
    localparam int TW  = $clog2(MIN_CLKS + 1);

    logic [NIN-1:0] sync_a;
    logic [NIN-1:0] sync_b;
    logic main_start, main_hv_low, main_stop, main_low, main_low_hyst;
    logic main_rst, reg_on, reg_uv, hs_uv, boost_uv, boost_start;
    logic out_ovp, mains_ok, cyc, ls_on, burst_idle, safe_mode;
    logic cyc_d;
    logic cyc_pulse;
    logic cycle_ovp;
    logic [CW-1:0] ovp_count;
    logic [TW-1:0] ovp_timer;
    logic ovp_trip;
    logic restart_hold;
    ovp_supervisor_pkg::sup_state_t state;

    // two-flop synchroniser for every asynchronous input
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {MAIN_ABOVE_START, MAIN_ABOVE_HV_LOW, MAIN_ABOVE_STOP,
                       MAIN_ABOVE_LOW, MAIN_ABOVE_LOW_HYST, MAIN_ABOVE_RESET,
                       REG_ABOVE_ON, REG_ABOVE_UV, HS_ABOVE_UV,
                       BOOST_ABOVE_UV, BOOST_ABOVE_START, OUT_ABOVE_OVP,
                       MAINS_OK, CYCLE_STROBE, LOW_SIDE_ON, BURST_IDLE,
                       SAFE_RESTART_MODE};
            sync_b <= sync_a;
        end
    end

    // name the synchronised levels
    assign {main_start, main_hv_low, main_stop, main_low, main_low_hyst,
            main_rst, reg_on, reg_uv, hs_uv, boost_uv, boost_start,
            out_ovp, mains_ok, cyc, ls_on, burst_idle, safe_mode} = sync_b;

    // rising edge of the switching cycle strobe
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            cyc_d <= 1'b0;
        end else begin
            cyc_d <= cyc;
        end
    end
    assign cyc_pulse = cyc & ~cyc_d;

    // overvoltage seen anywhere inside the current cycle; pulsed or steady
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || cyc_pulse) begin
            cycle_ovp <= 1'b0;
        end else if (out_ovp) begin
            cycle_ovp <= 1'b1;
        end
    end

    // count overvoltage cycles; clean cycle or stopped switching clears
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || !SWITCH_ENABLE) begin
            ovp_count <= '0;
        end else if (cyc_pulse) begin
            if (!(cycle_ovp || out_ovp)) begin
                ovp_count <= '0;
            end else if (ovp_count != CW'(OVP_COUNT)) begin
                ovp_count <= ovp_count + 1'b1;
            end
        end
    end

    // minimum delay timer runs while overvoltage persists
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || !SWITCH_ENABLE || ovp_count == '0) begin
            ovp_timer <= '0;
        end else if (ovp_timer != TW'(MIN_CLKS)) begin
            ovp_timer <= ovp_timer + 1'b1;
        end
    end

    // trip once the cycle count and the minimum time are met while overvoltage is present
    assign ovp_trip = (ovp_count == CW'(OVP_COUNT)) &&
                      (ovp_timer == TW'(MIN_CLKS)) && out_ovp;

    // protection and supervisor sequence
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || !main_rst) begin
            state        <= ovp_supervisor_pkg::ST_OFF;
            restart_hold <= 1'b0;
        end else begin
            case (state)
                ovp_supervisor_pkg::ST_OFF: begin
                    state <= ovp_supervisor_pkg::ST_CHARGE;
                end
                ovp_supervisor_pkg::ST_CHARGE: begin
                    if (main_start) begin
                        state <= ovp_supervisor_pkg::ST_WAIT_REG;
                    end
                end
                ovp_supervisor_pkg::ST_WAIT_REG: begin
                    if (!main_stop || !reg_uv) begin
                        state <= ovp_supervisor_pkg::ST_CHARGE;
                    end else if (reg_on) begin
                        state <= ovp_supervisor_pkg::ST_WAIT_BOOST;
                    end
                end
                ovp_supervisor_pkg::ST_WAIT_BOOST: begin
                    if (!main_stop || !reg_uv) begin
                        state <= ovp_supervisor_pkg::ST_CHARGE;
                    end else if (boost_start) begin
                        state <= ovp_supervisor_pkg::ST_RUN;
                    end
                end
                ovp_supervisor_pkg::ST_RUN: begin
                    if (!main_stop || !reg_uv) begin
                        state <= ovp_supervisor_pkg::ST_CHARGE;
                    end else if (ovp_trip) begin
                        state        <= ovp_supervisor_pkg::ST_PROTECT;
                        restart_hold <= safe_mode;
                    end else if (!boost_uv && ls_on) begin
                        state <= ovp_supervisor_pkg::ST_WAIT_BOOST;
                    end
                end
                ovp_supervisor_pkg::ST_PROTECT: begin
                    // safe restart recharges at once; latch waits for a fall
                    if (restart_hold || !main_stop || !mains_ok) begin
                        state <= ovp_supervisor_pkg::ST_CHARGE;
                    end
                end
                default: begin
                    state <= ovp_supervisor_pkg::ST_OFF;
                end
            endcase
        end
    end

    // high-voltage source: start-up hysteresis and burst-idle backup
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || !main_rst) begin
            HV_SOURCE_ON <= 1'b0;
        end else if (state == ovp_supervisor_pkg::ST_CHARGE ||
                     state == ovp_supervisor_pkg::ST_OFF) begin
            if (main_start) begin
                HV_SOURCE_ON <= 1'b0;
            end else if (!main_hv_low) begin
                HV_SOURCE_ON <= 1'b1;
            end
        end else if (state == ovp_supervisor_pkg::ST_RUN && burst_idle) begin
            if (!main_low) begin
                HV_SOURCE_ON <= 1'b1;
            end else if (main_low_hyst) begin
                HV_SOURCE_ON <= 1'b0;
            end
        end else begin
            HV_SOURCE_ON <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            SYSTEM_RESET      <= 1'b1;
            CONTROLLER_ENABLE <= 1'b0;
            SWITCH_ENABLE     <= 1'b0;
            HIGH_SIDE_ENABLE  <= 1'b0;
            OVP_LATCHED       <= 1'b0;
            SAMPLE_SETTING    <= 1'b0;
        end else begin
            SYSTEM_RESET      <= !main_rst;
            CONTROLLER_ENABLE <= state != ovp_supervisor_pkg::ST_OFF &&
                                 state != ovp_supervisor_pkg::ST_CHARGE;
            SWITCH_ENABLE     <= state == ovp_supervisor_pkg::ST_RUN &&
                                 !ovp_trip && main_stop && reg_uv &&
                                 !(!boost_uv && ls_on);
            HIGH_SIDE_ENABLE  <= state == ovp_supervisor_pkg::ST_RUN &&
                                 !ovp_trip && hs_uv;
            OVP_LATCHED       <= state == ovp_supervisor_pkg::ST_PROTECT;
            SAMPLE_SETTING    <= state == ovp_supervisor_pkg::ST_WAIT_REG;
        end
    end

    // assertions
    sequence trip_seq;
        ovp_trip && state == ovp_supervisor_pkg::ST_RUN && main_stop && reg_uv;
    endsequence

    ovp_stops_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        trip_seq |=> state == ovp_supervisor_pkg::ST_PROTECT ##1 !SWITCH_ENABLE)
        else $error("overvoltage trip did not stop switching");
    count_cap_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ovp_count <= CW'(OVP_COUNT))
        else $error("overvoltage counter overran");
    min_time_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ovp_trip |-> ovp_timer == TW'(MIN_CLKS))
        else $error("trip before minimum delay");
    clean_clear_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        SWITCH_ENABLE && cyc_pulse && !cycle_ovp && !out_ovp |=> ovp_count == '0)
        else $error("clean cycle did not clear counter");
    stop_clear_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !SWITCH_ENABLE |=> ovp_count == '0)
        else $error("counter held while stopped");
    reset_out_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !main_rst |=> SYSTEM_RESET && !HV_SOURCE_ON
            && state == ovp_supervisor_pkg::ST_OFF)
        else $error("reset level not followed");
    start_gate_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        $rose(CONTROLLER_ENABLE) |-> $past(main_start, 2))
        else $error("enabled before start level");
    hs_uv_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !hs_uv |=> !HIGH_SIDE_ENABLE)
        else $error("high side ran on low bootstrap");
    reg_uv_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !reg_uv |=> !SWITCH_ENABLE)
        else $error("switching on regulated undervoltage");
    latch_hold_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        state == ovp_supervisor_pkg::ST_PROTECT && !restart_hold && main_stop
            && mains_ok && main_rst |=> state == ovp_supervisor_pkg::ST_PROTECT)
        else $error("latch released without supply fall");

    // start-up source: on under the lower level, off at the start level
    hv_on_a: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        state == ovp_supervisor_pkg::ST_CHARGE && main_rst && !main_start
            && !main_hv_low |=> HV_SOURCE_ON)
        else $error("start-up source stayed off");
    hv_off_a: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        state == ovp_supervisor_pkg::ST_CHARGE && main_rst && main_start
            |=> !HV_SOURCE_ON)
        else $error("start-up source stayed on");

    // backup source while idle inside a burst
    sequence burst_low_seq;
        state == ovp_supervisor_pkg::ST_RUN && burst_idle && main_rst
            && !main_low;
    endsequence
    sequence burst_high_seq;
        state == ovp_supervisor_pkg::ST_RUN && burst_idle && main_rst
            && main_low && main_low_hyst;
    endsequence
    burst_on_a: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        burst_low_seq |=> HV_SOURCE_ON)
        else $error("backup source not switched on");
    burst_off_a: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        burst_high_seq |=> !HV_SOURCE_ON)
        else $error("backup source not released");

    // no switching before the run state is reached
    reg_gate_a: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        state == ovp_supervisor_pkg::ST_WAIT_REG ||
            state == ovp_supervisor_pkg::ST_WAIT_BOOST |=> !SWITCH_ENABLE)
        else $error("switching before regulation and boost start");

    // stop level leaves the run state and drops switching
    stop_level_a: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        state == ovp_supervisor_pkg::ST_RUN && main_rst && !main_stop
            |=> state == ovp_supervisor_pkg::ST_CHARGE && !SWITCH_ENABLE)
        else $error("converter ran below stop level");

    // boost undervoltage halt and restart
    sequence boost_low_seq;
        state == ovp_supervisor_pkg::ST_RUN && main_rst && main_stop
            && reg_uv && !ovp_trip && !boost_uv && ls_on;
    endsequence
    sequence boost_go_seq;
        state == ovp_supervisor_pkg::ST_WAIT_BOOST && main_rst && main_stop
            && reg_uv && boost_start;
    endsequence
    boost_halt_a: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        boost_low_seq |=> state == ovp_supervisor_pkg::ST_WAIT_BOOST
            && !SWITCH_ENABLE)
        else $error("boost undervoltage did not halt switching");
    boost_go_a: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        boost_go_seq |=> state == ovp_supervisor_pkg::ST_RUN)
        else $error("boost start level did not start switching");

    // safe restart leaves protection at once
    safe_restart_a: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        state == ovp_supervisor_pkg::ST_PROTECT && restart_hold && main_rst
            |=> state == ovp_supervisor_pkg::ST_CHARGE)
        else $error("safe restart did not recharge");
endmodule

// [verification/converter_far_side.sv]
/*
 * Far-side model: supply comparators and half-bridge gate timing.
 * Assumes supply levels in millivolts from the bench and a strobe period
 * of two half periods counted in system clocks; strobe stands still when idle.
 */
`timescale 1ns/10ps

module converter_far_side (
    // clock and gate side
    input  wire logic CLOCK,
    input  wire logic SWITCH_ENABLE,
    // levels in millivolts, strobe half period in clocks
    input  var  int   main_mv,
    input  var  int   reg_mv,
    input  var  int   hs_mv,
    input  var  int   boost_mv,
    input  var  int   half,
    // comparator results
    output logic      MAIN_ABOVE_START,
    output logic      MAIN_ABOVE_HV_LOW,
    output logic      MAIN_ABOVE_STOP,
    output logic      MAIN_ABOVE_LOW,
    output logic      MAIN_ABOVE_LOW_HYST,
    output logic      MAIN_ABOVE_RESET,
    output logic      REG_ABOVE_ON,
    output logic      REG_ABOVE_UV,
    output logic      HS_ABOVE_UV,
    output logic      BOOST_ABOVE_UV,
    output logic      BOOST_ABOVE_START,
    // gate timing
    output logic      CYCLE_STROBE,
    output logic      LOW_SIDE_ON
);
    int cnt = 0;
    // comparators with fixed thresholds
    assign MAIN_ABOVE_START    = main_mv > ovp_supervisor_pkg::START_MV;
    assign MAIN_ABOVE_HV_LOW   = main_mv > ovp_supervisor_pkg::START_MV
                                 - ovp_supervisor_pkg::HV_HYST_MV;
    assign MAIN_ABOVE_STOP     = main_mv > ovp_supervisor_pkg::STOP_MV;
    assign MAIN_ABOVE_LOW      = main_mv > ovp_supervisor_pkg::LOW_MV;
    assign MAIN_ABOVE_LOW_HYST = main_mv > ovp_supervisor_pkg::LOW_MV
                                 + ovp_supervisor_pkg::LOW_HYST_MV;
    assign MAIN_ABOVE_RESET    = main_mv > ovp_supervisor_pkg::RESET_MV;
    assign REG_ABOVE_ON        = reg_mv > ovp_supervisor_pkg::REG_ON_MV;
    assign REG_ABOVE_UV        = reg_mv > ovp_supervisor_pkg::REG_UV_MV;
    assign HS_ABOVE_UV         = hs_mv > ovp_supervisor_pkg::HS_UV_MV;
    assign BOOST_ABOVE_UV      = boost_mv > ovp_supervisor_pkg::BOOST_UV_MV;
    assign BOOST_ABOVE_START   = boost_mv > ovp_supervisor_pkg::BOOST_START_MV;
    // cycle position, held at zero while switching is off
    always_ff @(posedge CLOCK) begin
        if (!SWITCH_ENABLE || cnt >= 2 * half - 1) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // strobe in first half, low side conducting in second half
    assign CYCLE_STROBE = SWITCH_ENABLE && (cnt < half);
    assign LOW_SIDE_ON  = SWITCH_ENABLE && (cnt >= half);
endmodule

// [verification/converter_supply_ovp_supervisor_tb.sv]
/*
 * Bench for the supply and overvoltage supervisor: start-up, supply faults,
 * burst backup, boost and bootstrap faults, overvoltage delay and restart.
 * Assumes the far-side model and a shortened minimum delay of 60 clocks.
 */
`timescale 1ns/10ps

module converter_supply_ovp_supervisor_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic out_ovp = 1'b0;
    logic mains_ok = 1'b1;
    logic burst_idle = 1'b0;
    logic safe_mode = 1'b0;
    int   main_mv = 0, reg_mv = 0, hs_mv = 0, boost_mv = 0, half = 4;
    int   n_errors = 0, checks_done = 0, cycles = 0;
    logic a_st, a_hv, a_sp, a_lo, a_lh, a_rs, r_on, r_uv, h_uv, b_uv, b_st;
    logic strobe, low_on, sys_reset, ctrl_en, hv_on, sw_en, hs_en;
    logic latched, sample;

    // far side and device under test
    converter_far_side far (.CLOCK(clock), .SWITCH_ENABLE(sw_en),
        .main_mv(main_mv), .reg_mv(reg_mv), .hs_mv(hs_mv),
        .boost_mv(boost_mv), .half(half), .MAIN_ABOVE_START(a_st),
        .MAIN_ABOVE_HV_LOW(a_hv), .MAIN_ABOVE_STOP(a_sp),
        .MAIN_ABOVE_LOW(a_lo), .MAIN_ABOVE_LOW_HYST(a_lh),
        .MAIN_ABOVE_RESET(a_rs), .REG_ABOVE_ON(r_on), .REG_ABOVE_UV(r_uv),
        .HS_ABOVE_UV(h_uv), .BOOST_ABOVE_UV(b_uv),
        .BOOST_ABOVE_START(b_st), .CYCLE_STROBE(strobe),
        .LOW_SIDE_ON(low_on));
    ovp_supervisor #(.OVP_COUNT(11), .MIN_CLKS(60)) dut (.CLOCK(clock),
        .SYS_RST(sys_rst), .MAIN_ABOVE_START(a_st),
        .MAIN_ABOVE_HV_LOW(a_hv), .MAIN_ABOVE_STOP(a_sp),
        .MAIN_ABOVE_LOW(a_lo), .MAIN_ABOVE_LOW_HYST(a_lh),
        .MAIN_ABOVE_RESET(a_rs), .REG_ABOVE_ON(r_on), .REG_ABOVE_UV(r_uv),
        .HS_ABOVE_UV(h_uv), .BOOST_ABOVE_UV(b_uv),
        .BOOST_ABOVE_START(b_st), .OUT_ABOVE_OVP(out_ovp),
        .MAINS_OK(mains_ok), .CYCLE_STROBE(strobe), .LOW_SIDE_ON(low_on),
        .BURST_IDLE(burst_idle), .SAFE_RESTART_MODE(safe_mode),
        .SYSTEM_RESET(sys_reset), .CONTROLLER_ENABLE(ctrl_en),
        .HV_SOURCE_ON(hv_on), .SWITCH_ENABLE(sw_en),
        .HIGH_SIDE_ENABLE(hs_en), .OVP_LATCHED(latched),
        .SAMPLE_SETTING(sample));

    // 50 MHz clock
    initial begin
        forever #10 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic chk(input logic seen, input logic exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic boot();
        main_mv = 19500; reg_mv = 12000; hs_mv = 10000; boost_mv = 2500;
        out_ovp = 1'b0;
        step(40);
        chk(sw_en, 1'b1);
    endtask
    task automatic startup();
        hs_mv = 10000; main_mv = 15000; reg_mv = 10000; step(8);
        chk(ctrl_en, 1'b0);
        chk(hv_on, 1'b1);
        main_mv = 18800; step(8);
        chk(hv_on, 1'b1);
        main_mv = 19500; step(8);
        chk(ctrl_en, 1'b1);
        chk(sample, 1'b1);
        chk(hv_on, 1'b0);
        main_mv = 18000; step(8);
        chk(hv_on, 1'b0);
        main_mv = 19500; reg_mv = 12000; step(8);
        chk(sw_en, 1'b0);
        boost_mv = 2500; step(8);
        chk(sw_en, 1'b1);
        chk(sample, 1'b0);
    endtask
    task automatic faults();
        hs_mv = 5000; step(8);
        chk(hs_en, 1'b0);
        chk(sw_en, 1'b1);
        hs_mv = 10000; boost_mv = 1500; step(8);
        chk(sw_en, 1'b0);
        boost_mv = 2000; step(8);
        chk(sw_en, 1'b0);
        boost(); reg_mv = 8000; step(8);
        chk(sw_en, 1'b0);
        boot(); main_mv = 13000; step(8);
        chk(sw_en, 1'b0);
        chk(ctrl_en, 1'b0);
        main_mv = 3000; step(8);
        chk(sys_reset, 1'b1);
    endtask
    task automatic boost();
        boost_mv = 2500; step(12);
        chk(sw_en, 1'b1);
    endtask
    task automatic burst();
        boot(); burst_idle = 1'b1; main_mv = 14500; step(8);
        chk(hv_on, 1'b0);
        main_mv = 13900; step(8);
        chk(hv_on, 1'b1);
        main_mv = 14500; step(8);
        chk(hv_on, 1'b1);
        main_mv = 15000; step(8);
        chk(hv_on, 1'b0);
        burst_idle = 1'b0;
    endtask
    task automatic ovp_count();
        boot(); out_ovp = 1'b1; step(56);
        out_ovp = 1'b0; step(16);
        out_ovp = 1'b1; step(72);
        chk(latched, 1'b0);
        step(32);
        chk(latched, 1'b1);
        chk(sw_en, 1'b0);
        out_ovp = 1'b0; step(20);
        chk(latched, 1'b1);
        mains_ok = 1'b0; step(8);
        chk(latched, 1'b0);
        mains_ok = 1'b1;
    endtask
    task automatic ovp_fast();
        half = 1; boot(); out_ovp = 1'b1; step(40);
        chk(latched, 1'b0);
        step(30);
        chk(latched, 1'b1);
        main_mv = 13000; out_ovp = 1'b0; step(8);
        chk(latched, 1'b0);
        half = 4; safe_mode = 1'b1; boot(); out_ovp = 1'b1; step(104);
        out_ovp = 1'b0; step(40);
        chk(sw_en, 1'b1);
        chk(latched, 1'b0);
    endtask

    // main sequence
    initial begin
        step(16);
        chk(sys_reset, 1'b1);
        chk(sw_en, 1'b0);
        sys_rst = 1'b0;
        startup();
        faults();
        burst();
        ovp_count();
        ovp_fast();
        final_report();
    end
endmodule
